// [trim_status_consts.svh]
`ifndef TRIM_STATUS_CONSTS_SVH
`define TRIM_STATUS_CONSTS_SVH

`define CHANNELS 16
`define TRIM_CODE_W 7
`define TRIM_CHAIN_BITS 112
`define TRIM_CODE_ZERO 7'h00
`define TRIM_CODE_FULL 7'h7f
`define TRIM_STEPS 128
`define GRAY_CHAIN_BITS 192
`define STATUS_BITS 17
`define STATUS_TOP_BIT 191
`define STATUS_LOW_BIT 175
`define OPEN_LOAD_SAVE_EDGE 8'h21
`define EDGE_COUNT_W 8
`define EDGE_COUNT_MAX 8'hff

`endif

// [trim_status_pkg.sv]
package trim_status_pkg;

  typedef struct packed {
    logic [15:0] open_load_flag;
    logic overtemp_flag;
  } status_snapshot_t;

  typedef logic [6:0] channel_trim_code_t;

  typedef channel_trim_code_t [15:0] current_trim_t;

  typedef struct packed {
    logic shift_clock;
    logic serial_in;
    logic latch_strobe;
  } trim_port_t;

  typedef enum logic [1:0] {
    GRAY_SHIFT = 2'b01,
    GRAY_STROBE = 2'b10
  } gray_phase_t;

endpackage

// [sync2.sv]
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;

  // First stage is read only by the second stage
  always_comb
  begin
    next_meta = d_i;
    next_stable = meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta <= '0;
      stable <= '0;
    end
    else
    begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign q_o = stable;
endmodule

// [led_current_trim_status_capture.sv]
`timescale 1ns/1ps
`include "trim_status_consts.svh"

module led_current_trim_status_capture #(
  parameter int CHANNELS = `CHANNELS,
  parameter int TRIM_BITS = `TRIM_CHAIN_BITS,
  parameter int GRAY_BITS = `GRAY_CHAIN_BITS
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic gray_shift_clock_i,
  input wire logic gray_serial_in_i,
  input wire logic gray_latch_strobe_i,
  input wire logic trim_shift_clock_i,
  input wire logic trim_serial_in_i,
  input wire logic trim_latch_strobe_i,
  input wire logic [15:0] open_load_flag_i,
  input wire logic overtemp_flag_i,
  output logic gray_serial_out_o,
  output logic [GRAY_BITS-1:0] brightness_level_o,
  output trim_status_pkg::current_trim_t current_trim_o,
  output logic [15:0] channel_sink_enable_o,
  output logic trim_latch_update_o
);

  // Reset release, main domain
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic rst_b;

  always_comb
  begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= next_rst_pipe;
  end

  assign rst_b = rst_pipe[1];

  // Reset release, gray link domain; the link clock may stop, so this
  // only releases once the controller starts clocking
  logic [1:0] gray_rst_pipe;
  logic [1:0] next_gray_rst_pipe;
  logic gray_rst_b;

  always_comb
  begin
    next_gray_rst_pipe = {gray_rst_pipe[0], 1'b1};
  end

  always_ff @(posedge gray_shift_clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gray_rst_pipe <= 2'b00;
    else
      gray_rst_pipe <= next_gray_rst_pipe;
  end

  assign gray_rst_b = gray_rst_pipe[1];

  // Trim port pins are sampled in the main domain
  trim_status_pkg::trim_port_t trim_pins;
  trim_status_pkg::trim_port_t trim_sync;
  trim_status_pkg::trim_port_t trim_prev;
  trim_status_pkg::trim_port_t next_trim_prev;

  assign trim_pins.shift_clock = trim_shift_clock_i;
  assign trim_pins.serial_in = trim_serial_in_i;
  assign trim_pins.latch_strobe = trim_latch_strobe_i;

  sync2 #(.WIDTH(3)) trim_sync_u (
    .clk_i(mclk_i),
    .rst_b_i(rst_b),
    .d_i(trim_pins),
    .q_o(trim_sync)
  );

  // Data and clock share one sync path, so data must be steady around the
  // trim clock rise for at least two main clock periods
  logic trim_shift_rise;
  logic trim_strobe_rise;

  always_comb
  begin
    next_trim_prev = trim_sync;
    trim_shift_rise = trim_sync.shift_clock && !trim_prev.shift_clock;
    trim_strobe_rise = trim_sync.latch_strobe && !trim_prev.latch_strobe;
  end

  always_ff @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
      trim_prev <= '0;
    else
      trim_prev <= next_trim_prev;
  end

  // Trim chain and latch hold no reset, contents are unknown until written
  logic [TRIM_BITS-1:0] trim_chain;
  logic [TRIM_BITS-1:0] next_trim_chain;
  trim_status_pkg::current_trim_t trim_latch;
  trim_status_pkg::current_trim_t next_trim_latch;
  logic [15:0] next_sink_enable;
  logic [15:0] sink_enable;
  logic next_update;
  logic update;

  always_comb
  begin
    next_trim_chain = trim_chain;
    next_trim_latch = trim_latch;
    if (trim_shift_rise)
      next_trim_chain = {trim_chain[TRIM_BITS-2:0], trim_sync.serial_in};
    if (trim_strobe_rise)
      next_trim_latch = trim_status_pkg::current_trim_t'(trim_chain);
    // A zero code sinks no current, so its channel is held off
    for (int ch = 0; ch < CHANNELS; ch++)
      next_sink_enable[ch] = (next_trim_latch[ch] != `TRIM_CODE_ZERO);
  end

  always_ff @(posedge mclk_i)
  begin
    trim_chain <= next_trim_chain;
    trim_latch <= next_trim_latch;
    sink_enable <= next_sink_enable;
  end

  // The strobe pulse is the only trim output that has a reset value
  always_comb
  begin
    next_update = trim_strobe_rise;
  end

  always_ff @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
      update <= 1'b0;
    else
      update <= next_update;
  end

  // Codes feed the current DAC, which sinks full scale times code over 127
  assign current_trim_o = trim_latch;
  assign channel_sink_enable_o = sink_enable;
  assign trim_latch_update_o = update;

  // Status sources, registered in the main domain then crossed as levels;
  // a flag changing during the crossing is caught one edge later
  trim_status_pkg::status_snapshot_t status_raw;
  trim_status_pkg::status_snapshot_t next_status_raw;
  trim_status_pkg::status_snapshot_t status_gray;

  always_comb
  begin
    next_status_raw.open_load_flag = open_load_flag_i;
    next_status_raw.overtemp_flag = overtemp_flag_i;
  end

  always_ff @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
      status_raw <= '0;
    else
      status_raw <= next_status_raw;
  end

  // Flags are quasi-static, so a plain two-flop crossing is enough
  sync2 #(.WIDTH(`STATUS_BITS)) status_sync_u (
    .clk_i(gray_shift_clock_i),
    .rst_b_i(gray_rst_b),
    .d_i(status_raw),
    .q_o(status_gray)
  );

  // Gray link domain
  trim_status_pkg::gray_phase_t phase;
  trim_status_pkg::gray_phase_t next_phase;
  logic [`EDGE_COUNT_W-1:0] edge_count;
  logic [`EDGE_COUNT_W-1:0] next_edge_count;
  logic [15:0] open_load_saved;
  logic [15:0] next_open_load_saved;
  logic [GRAY_BITS-1:0] gray_chain;
  logic [GRAY_BITS-1:0] next_gray_chain;
  logic [GRAY_BITS-1:0] gray_latch;
  logic [GRAY_BITS-1:0] next_gray_latch;
  logic serial_out;
  logic next_serial_out;
  logic snapshot_load;
  trim_status_pkg::status_snapshot_t snapshot;

  // The load edge is the first rise that finds the strobe low again
  always_comb
  begin
    next_phase = phase;
    snapshot_load = 1'b0;
    case (phase)
      trim_status_pkg::GRAY_SHIFT:
        if (gray_latch_strobe_i)
          next_phase = trim_status_pkg::GRAY_STROBE;
      trim_status_pkg::GRAY_STROBE:
        if (!gray_latch_strobe_i)
        begin
          next_phase = trim_status_pkg::GRAY_SHIFT;
          snapshot_load = 1'b1;
        end
      default:
        next_phase = trim_status_pkg::GRAY_SHIFT;
    endcase
  end

  always_ff @(posedge gray_shift_clock_i or negedge gray_rst_b)
  begin
    if (!gray_rst_b)
      phase <= trim_status_pkg::GRAY_SHIFT;
    else
      phase <= next_phase;
  end

  // Count saturates, so a stalled period never wraps back onto edge 33
  always_comb
  begin
    next_edge_count = edge_count;
    next_open_load_saved = open_load_saved;
    // The load edge is edge one of the new display period
    if (snapshot_load)
      next_edge_count = 8'h01;
    else if (edge_count != `EDGE_COUNT_MAX)
      next_edge_count = edge_count + 8'h01;
    if (next_edge_count == `OPEN_LOAD_SAVE_EDGE && edge_count != `OPEN_LOAD_SAVE_EDGE)
      next_open_load_saved = status_gray.open_load_flag;
  end

  always_ff @(posedge gray_shift_clock_i or negedge gray_rst_b)
  begin
    if (!gray_rst_b)
    begin
      edge_count <= '0;
      open_load_saved <= '0;
    end
    else
    begin
      edge_count <= next_edge_count;
      open_load_saved <= next_open_load_saved;
    end
  end

  // Open-load part stays frozen from edge 33 of the last period
  always_comb
  begin
    snapshot.open_load_flag = open_load_saved;
    snapshot.overtemp_flag = status_gray.overtemp_flag;
  end

  // Brightness storage has no defined power-up value either
  always_comb
  begin
    next_gray_chain = {gray_chain[GRAY_BITS-2:0], gray_serial_in_i};
    if (snapshot_load)
      next_gray_chain = {snapshot, gray_chain[`STATUS_LOW_BIT-1:0]};
    next_gray_latch = gray_latch;
    // Taken at a clock rise with the strobe high, so no third clock is needed
    if (phase == trim_status_pkg::GRAY_SHIFT && gray_latch_strobe_i)
      next_gray_latch = gray_chain;
  end

  always_ff @(posedge gray_shift_clock_i)
  begin
    gray_chain <= next_gray_chain;
    gray_latch <= next_gray_latch;
  end

  // Registered so the pin shows the chain top without glitches
  always_comb
  begin
    next_serial_out = next_gray_chain[GRAY_BITS-1];
  end

  always_ff @(posedge gray_shift_clock_i or negedge gray_rst_b)
  begin
    if (!gray_rst_b)
      serial_out <= 1'b0;
    else
      serial_out <= next_serial_out;
  end

  assign gray_serial_out_o = serial_out;
  assign brightness_level_o = gray_latch;

endmodule

// [tsc_chk_sva.sv]
`timescale 1ns/1ps
module tsc_chk #(
  parameter int GRAY_BITS = 192
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic gray_shift_clock_i,
  input wire logic gray_serial_in_i,
  input wire logic gray_latch_strobe_i,
  input wire logic trim_latch_strobe_i,
  input wire logic [15:0] open_load_flag_i,
  input wire logic overtemp_flag_i,
  input wire logic gray_serial_out_o,
  input wire logic [GRAY_BITS-1:0] brightness_level_o,
  input wire trim_status_pkg::current_trim_t current_trim_o,
  input wire logic [15:0] channel_sink_enable_o,
  input wire logic trim_latch_update_o
);
  logic prev, next_prev;
  logic [7:0] ecnt, next_ecnt;
  logic [15:0] saved, next_saved, nz;
  always_comb
  begin
    next_prev = gray_latch_strobe_i;
    next_ecnt = (ecnt == 8'h00 || ecnt == 8'hff) ? ecnt : ecnt + 8'h01;
    if (prev && !gray_latch_strobe_i)
      next_ecnt = 8'h01;
    // Edge 33 of a period sees a count of 32
    next_saved = (ecnt == 8'h20) ? open_load_flag_i : saved;
    for (int n = 0; n < 16; n++)
      nz[n] = |current_trim_o[n];
  end
  always_ff @(posedge gray_shift_clock_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      prev <= 1'b0;
      ecnt <= 8'h00;
      saved <= 16'h0000;
    end
    else
    begin
      prev <= next_prev;
      ecnt <= next_ecnt;
      saved <= next_saved;
    end
  sequence load_s;
    $fell(gray_latch_strobe_i);
  endsequence
  load_head_a: assert property (@(posedge gray_shift_clock_i) disable iff (!rst_b_i)
    load_s |=> gray_serial_out_o == saved[15] ##1 gray_serial_out_o == saved[14])
    else $error("status head wrong");
  load_temp_a: assert property (@(posedge gray_shift_clock_i) disable iff (!rst_b_i)
    load_s |-> ##17 gray_serial_out_o == $past(overtemp_flag_i, 17))
    else $error("thermal bit wrong");
  gray_latch_a: assert property (@(posedge gray_shift_clock_i) disable iff (!rst_b_i)
    $rose(gray_latch_strobe_i) |=> brightness_level_o[GRAY_BITS-1] == $past(gray_serial_out_o)
    && brightness_level_o[0] == $past(gray_serial_in_i, 2)) else $error("gray latch wrong");
  trim_update_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(trim_latch_strobe_i) |-> ##[1:8] trim_latch_update_o) else $error("no trim update");
  update_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    trim_latch_update_o |=> !trim_latch_update_o) else $error("update pulse too long");
  trim_whole_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $changed(current_trim_o) |-> trim_latch_update_o) else $error("trim changed without update");
  update_cause_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    trim_latch_update_o |-> $past(trim_latch_strobe_i)) else $error("update without strobe");
  sink_enable_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    trim_latch_update_o |-> channel_sink_enable_o == nz) else $error("sink enable wrong");
endmodule

bind led_current_trim_status_capture tsc_chk #(.GRAY_BITS(GRAY_BITS)) tsc_chk_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .gray_shift_clock_i(gray_shift_clock_i),
  .gray_serial_in_i(gray_serial_in_i), .gray_latch_strobe_i(gray_latch_strobe_i),
  .trim_latch_strobe_i(trim_latch_strobe_i), .open_load_flag_i(open_load_flag_i),
  .overtemp_flag_i(overtemp_flag_i), .gray_serial_out_o(gray_serial_out_o),
  .brightness_level_o(brightness_level_o), .current_trim_o(current_trim_o),
  .channel_sink_enable_o(channel_sink_enable_o), .trim_latch_update_o(trim_latch_update_o));

// [gray_model.sv]
`timescale 1ns/1ps
module gray_model (
  output logic gray_shift_clock_o,
  output logic gray_serial_in_o,
  output logic gray_latch_strobe_o,
  input wire logic gray_serial_out_i
);
  logic [17:0] cap = '0;
  int edges = 0;
  initial
  begin
    gray_shift_clock_o = 1'b0;
    gray_serial_in_o = 1'b0;
    gray_latch_strobe_o = 1'b0;
  end
  // Clock stands low between frames, so every rise is one we asked for
  task automatic pulse();
    #3 gray_shift_clock_o = 1'b1;
    edges++;
    #3 gray_shift_clock_o = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      gray_serial_in_o = ~gray_serial_in_o;
      pulse();
    end
  endtask
  // Optional load edge, 192 bits MSB first, then one strobe edge
  task automatic frame(input logic [191:0] d, input logic rd);
    edges = 0;
    for (int i = rd ? 0 : 1; i <= 193; i++)
    begin
      gray_serial_in_o = (i >= 1 && i <= 192) ? d[192-i] : ~gray_serial_in_o;
      gray_latch_strobe_o = (i == 193);
      pulse();
      if (i <= 17)
        cap[17-i] = gray_serial_out_i;
    end
    gray_latch_strobe_o = 1'b0;
  endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tclk = 1'b0;
  logic tsin = 1'b0;
  logic tstb = 1'b0;
  logic ot = 1'b0;
  logic [15:0] ol = 16'h0000;
  wire logic gclk, gsin, gstb;
  logic gsout, upd;
  logic [191:0] bl;
  logic [15:0] en;
  trim_status_pkg::current_trim_t ct;
  int failures = 0;
  int compares = 0;
  always #20 mclk_i = ~mclk_i;
  led_current_trim_status_capture led_current_trim_status_capture_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .gray_shift_clock_i(gclk), .gray_serial_in_i(gsin),
    .gray_latch_strobe_i(gstb), .trim_shift_clock_i(tclk), .trim_serial_in_i(tsin),
    .trim_latch_strobe_i(tstb), .open_load_flag_i(ol), .overtemp_flag_i(ot),
    .gray_serial_out_o(gsout), .brightness_level_o(bl), .current_trim_o(ct),
    .channel_sink_enable_o(en), .trim_latch_update_o(upd));
  gray_model gray_model_inst (.gray_shift_clock_o(gclk), .gray_serial_in_o(gsin),
    .gray_latch_strobe_o(gstb), .gray_serial_out_i(gsout));
  task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Trim pins pass a 2FF, so each level is held at least two mclk cycles
  task automatic twrite(input trim_status_pkg::current_trim_t v);
    logic [111:0] f;
    logic [15:0] e;
    f = v;
    for (int i = 111; i >= 0; i--)
    begin
      tsin <= f[i];
      @(posedge mclk_i);
      tclk <= 1'b1;
      repeat (2) @(posedge mclk_i);
      tclk <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
    tstb <= 1'b1;
    for (int n = 0; n < 20 && upd !== 1'b1; n++)
      @(posedge mclk_i);
    for (int n = 0; n < 16; n++)
      e[n] = v[n] != 7'h00;
    chk(192'(upd), 192'h1);
    chk(192'(ct), 192'(v));
    chk(192'(en), 192'(e));
    repeat (2) @(posedge mclk_i);
    tstb <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  function automatic logic [191:0] gpat(input int k);
    for (int i = 0; i < 192; i++)
      gpat[i] = k[0] ? i[3] : ~i[2];
  endfunction
  initial
  begin
    trim_status_pkg::current_trim_t v;
    trim_status_pkg::status_snapshot_t st;
    logic [191:0] d;
    logic [191:0] p;
    fork
      begin
        #400000;
        failures++;
        summarize();
      end
    join_none
    gray_model_inst.idle(4);
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    gray_model_inst.idle(6);
    @(posedge mclk_i);
    // Trim codes go in before anything is lit
    for (int w = 0; w < 2; w++)
    begin
      for (int n = 0; n < 16; n++)
        v[n] = w ? 7'(7'h7f - n) : (n == 15 ? 7'h7f : 7'(n * 8));
      twrite(v);
    end
    $display("trim test done");
    p = '0;
    for (int f = 1; f <= 3; f++)
    begin
      d = gpat(f);
      @(posedge mclk_i);
      if (f == 2)
        ol <= 16'ha5c3;
      // Flags change after edge 33, so only the saved open-load copy may show; the overtemp bit is live
      fork
        gray_model_inst.frame(d, f > 1);
        if (f == 2)
        begin
          wait (gray_model_inst.edges == 40);
          @(posedge mclk_i);
          ol <= 16'h5a3c;
          ot <= 1'b1;
        end
      join
      st = '0;
      if (f == 3)
        st = '{16'ha5c3, 1'b1};
      chk(bl, d);
      if (f > 1)
        chk(192'(gray_model_inst.cap), 192'({st, p[173]}));
      p = d;
    end
    $display("gray test done");
    summarize();
  end
endmodule
